// ===== bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] hold_ff;

   if (W < 1)
   begin
      $error("bit_sync: W must be at least 1");
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_ff <= '0;
         hold_ff <= '0;
      end
      else
      begin
         meta_ff <= d_in;
         hold_ff <= meta_ff;
      end
   end

   assign q_out = hold_ff;
endmodule
`default_nettype wire

// ===== serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clr_in,
   input wire logic go_in,
   input wire logic lvl_in,
   input wire logic sclk_in,
   input wire logic txd_in,
   output logic sclk_out,
   output logic fs_out,
   output logic rxd_out,
   output logic [31:0] cap_out,
   output logic [7:0] cnt_out
);
   logic last_ff, half_ff, clk_ff;
   logic [1:0] div_ff;
   logic [31:0] cap_ff;
   logic [7:0] cnt_ff;
   wire edge_seen = sclk_in != last_ff;
   assign sclk_out = clk_ff;
   assign fs_out = go_in;
   assign rxd_out = lvl_in;
   assign cap_out = cap_ff;
   assign cnt_out = cnt_ff;
   // slave clock: a level per 4 link cycles, still outside frames
   always_ff @(posedge clk_in or posedge rst_in)
      if (rst_in)
      begin
         {last_ff, half_ff, clk_ff, div_ff, cap_ff, cnt_ff} <= '0;
      end
      else
      begin
         last_ff <= sclk_in;
         half_ff <= clr_in ? 1'b0 : half_ff ^ edge_seen;
         div_ff <= div_ff + 2'h1;
         clk_ff <= clk_ff ^ (go_in && div_ff == 2'h3);
         if (clr_in)
         begin
            cap_ff <= 32'h0;
            cnt_ff <= 8'h0;
         end
         else if (edge_seen && !half_ff)
         begin
            cap_ff <= {cap_ff[30:0], txd_in};
            cnt_ff <= cnt_ff + 8'h1;
         end
      end
endmodule
`default_nettype wire

// ===== serial_port_format_control.sv
// Functional notes
// - polarity bit 0 active high, 1 active low
// - frame polarity only in I2S, command formats
// - I2S justify 0: zero padding after word
// - I2S justify 1: zero padding before word
// - non-I2S mode 00/01 slave, 10/11 master
// - I2S modes: master/slave, stereo/mono
// - SPI polarity 0: clock idles low
// - SPI polarity 1: clock idles high
// - SPI phase 0: clock after full period
// - SPI phase 1: clock after half period
// - format field selects SSP/SPI/command/I2S
// - padding length zero inserts no padding
package fmt_ctl_pkg;
   localparam logic [2:0] FMT_SSP = 3'h0;
   localparam logic [2:0] FMT_SPI = 3'h1;
   localparam logic [2:0] FMT_CMD = 3'h2;
   localparam logic [2:0] FMT_I2S = 3'h3;
   localparam int OPM_MASTER_BIT = 1;
   localparam int OPM_STEREO_BIT = 0;
   localparam int DATA_W_DEF = 16;
   localparam int PAD_W = 8;
   localparam int CFG_W = 17;
   localparam logic [3:0] LEAD_FULL = 4'h2;
   localparam logic [3:0] LEAD_HALF = 4'h1;
   localparam logic [3:0] LEAD_OTHER = 4'h1;
endpackage

`timescale 1ns/1ps
`default_nettype none
module serial_port_format_control #(
   parameter int DATA_W = fmt_ctl_pkg::DATA_W_DEF
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic LINK_CLK_IN,
   input wire logic [2:0] FRAME_FORMAT_SELECT_IN,
   input wire logic FRAME_SYNC_POLARITY_IN,
   input wire logic PADDING_JUSTIFY_IN,
   input wire logic [1:0] OPERATION_MODE_IN,
   input wire logic SERIAL_CLOCK_POLARITY_IN,
   input wire logic SERIAL_CLOCK_PHASE_IN,
   input wire logic [fmt_ctl_pkg::PAD_W-1:0] PADDING_LENGTH_IN,
   input wire logic START_IN,
   input wire logic [2*DATA_W-1:0] TX_DATA_IN,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output logic [2*DATA_W-1:0] RX_DATA_OUT,
   input wire logic SCLK_IN,
   input wire logic FS_IN,
   input wire logic RXD_IN,
   output logic SCLK_OUT,
   output logic SCLK_OE_OUT,
   output logic FS_OUT,
   output logic FS_OE_OUT,
   output logic TXD_OUT
);
   localparam int SLOT_W = fmt_ctl_pkg::PAD_W + 2;

   if (DATA_W < 4 || DATA_W > 256)
   begin
      $error("serial_port_format_control: DATA_W must be 4 to 256");
   end

   typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_LEAD, ST_SHIFT, ST_END} state_type;

   // system domain
   logic busy_ff, done_ff, start_tgl_ff, done_seen_ff, done_tgl_s;
   logic [2*DATA_W-1:0] tx_hold_ff, rx_out_ff;
   // link domain, read here only after its toggle has crossed
   logic done_tgl_ff;
   logic [2*DATA_W-1:0] rx_sh_ff;

   wire fmt_ok = FRAME_FORMAT_SELECT_IN <= fmt_ctl_pkg::FMT_I2S;
   wire take_start = START_IN && !busy_ff && fmt_ok;
   wire done_evt = done_tgl_s ^ done_seen_ff;

   bit_sync #(.W(1)) done_sync_i (
      .clk_in(SYS_CLK_IN),
      .rst_in(RST_IN),
      .d_in(done_tgl_ff),
      .q_out(done_tgl_s)
   );

   always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         {busy_ff, done_ff, start_tgl_ff, done_seen_ff} <= '0;
         {tx_hold_ff, rx_out_ff} <= '0;
      end
      else if (CE_IN)
      begin
         done_seen_ff <= done_tgl_s;
         done_ff <= done_evt;
         if (done_evt)
         begin
            busy_ff <= 1'b0;
            rx_out_ff <= rx_sh_ff;
         end
         else if (take_start)
         begin
            busy_ff <= 1'b1;
            start_tgl_ff <= ~start_tgl_ff;
            tx_hold_ff <= TX_DATA_IN;
         end
      end
   end

   assign BUSY_OUT = busy_ff;
   assign DONE_OUT = done_ff;
   assign RX_DATA_OUT = rx_out_ff;

   // link domain: settings are quasi-static, so per-bit synchronisers suffice
   logic [fmt_ctl_pkg::CFG_W-1:0] cfg_s;
   logic [1:0] ctl_s;
   logic [2:0] pin_s;
   bit_sync #(.W(fmt_ctl_pkg::CFG_W)) cfg_sync_i (
      .clk_in(LINK_CLK_IN),
      .rst_in(RST_IN),
      .d_in({FRAME_FORMAT_SELECT_IN, FRAME_SYNC_POLARITY_IN, PADDING_JUSTIFY_IN,
             OPERATION_MODE_IN, SERIAL_CLOCK_POLARITY_IN, SERIAL_CLOCK_PHASE_IN,
             PADDING_LENGTH_IN}),
      .q_out(cfg_s)
   );
   bit_sync #(.W(2)) ctl_sync_i (
      .clk_in(LINK_CLK_IN),
      .rst_in(RST_IN),
      .d_in({CE_IN, start_tgl_ff}),
      .q_out(ctl_s)
   );
   bit_sync #(.W(3)) pin_sync_i (
      .clk_in(LINK_CLK_IN),
      .rst_in(RST_IN),
      .d_in({SCLK_IN, FS_IN, RXD_IN}),
      .q_out(pin_s)
   );

   wire [2:0] fmt = cfg_s[16:14];
   wire frame_sync_polarity = cfg_s[13];
   wire justify = cfg_s[12];
   wire [1:0] operation_mode = cfg_s[11:10];
   wire cpol = cfg_s[9];
   wire cpha = cfg_s[8];
   wire [fmt_ctl_pkg::PAD_W-1:0] pad_len = cfg_s[7:0];
   wire lce = ctl_s[1];
   wire sclk_s = pin_s[2];
   wire fs_s = pin_s[1];
   wire rxd_s = pin_s[0];

   wire is_spi = fmt == fmt_ctl_pkg::FMT_SPI;
   wire is_i2s = fmt == fmt_ctl_pkg::FMT_I2S;
   wire master = operation_mode[fmt_ctl_pkg::OPM_MASTER_BIT];
   wire stereo = is_i2s && operation_mode[fmt_ctl_pkg::OPM_STEREO_BIT];
   wire fs_on = (is_i2s || fmt == fmt_ctl_pkg::FMT_CMD) ? ~frame_sync_polarity : 1'b1;
   wire sclk_idle = is_spi ? cpol : 1'b0;
   wire [3:0] lead_len = !is_spi ? fmt_ctl_pkg::LEAD_OTHER :
                         (cpha ? fmt_ctl_pkg::LEAD_HALF : fmt_ctl_pkg::LEAD_FULL);
   wire [fmt_ctl_pkg::PAD_W-1:0] pad_eff = is_i2s ? pad_len : '0;
   wire [SLOT_W-1:0] pad_front = justify ? SLOT_W'(pad_eff) : '0;
   wire [SLOT_W-1:0] slot_last = SLOT_W'(DATA_W - 1) + SLOT_W'(pad_eff);

   state_type state_ff;
   logic st_seen_ff, sclk_p_ff, half_ff, ch_ff;
   logic [3:0] lead_ff;
   logic [SLOT_W-1:0] slot_ff;
   logic sclk_out_ff, sclk_oe_ff, fs_out_ff, fs_oe_ff, txd_ff;

   wire req = ctl_s[0] ^ st_seen_ff;
   wire tick = master ? 1'b1 : (sclk_s ^ sclk_p_ff);
   wire [SLOT_W-1:0] nxt_slot = (state_ff == ST_SHIFT) && (slot_ff != slot_last) ?
                                slot_ff + SLOT_W'(1) : '0;
   wire nxt_ch = (state_ff == ST_SHIFT) && (slot_ff == slot_last) ? 1'b1 : ch_ff;

   // data bit for a slot: zeros in padding, MSB first in the word
   function automatic logic slot_bit(input logic [SLOT_W-1:0] s,
                                     input logic [DATA_W-1:0] w);
      logic [SLOT_W-1:0] idx;
      idx = s - pad_front;
      if (s < pad_front || idx >= SLOT_W'(DATA_W))
         slot_bit = 1'b0;
      else
         slot_bit = w[DATA_W-1-int'(idx)];
   endfunction

   wire [DATA_W-1:0] word_now = (stereo && !nxt_ch) ? tx_hold_ff[2*DATA_W-1:DATA_W]
                                                    : tx_hold_ff[DATA_W-1:0];
   wire slot_data = slot_ff >= pad_front && slot_ff < pad_front + SLOT_W'(DATA_W);
   wire frame_end = slot_ff == slot_last && (ch_ff || !stereo);

   always_ff @(posedge LINK_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         state_ff <= ST_IDLE;
         {st_seen_ff, sclk_p_ff, half_ff, ch_ff, lead_ff, slot_ff, done_tgl_ff} <= '0;
         {rx_sh_ff, sclk_out_ff, sclk_oe_ff, fs_out_ff, fs_oe_ff, txd_ff} <= '0;
      end
      else if (lce)
      begin
         sclk_p_ff <= sclk_s;
         case (state_ff)
            ST_IDLE:
            begin
               sclk_out_ff <= sclk_idle;
               fs_out_ff <= ~fs_on;
               sclk_oe_ff <= master;
               fs_oe_ff <= master;
               if (req)
               begin
                  st_seen_ff <= ctl_s[0];
                  ch_ff <= 1'b0;
                  half_ff <= 1'b0;
                  slot_ff <= '0;
                  lead_ff <= lead_len - 4'h1;
                  txd_ff <= slot_bit('0, stereo ? tx_hold_ff[2*DATA_W-1:DATA_W]
                                                : tx_hold_ff[DATA_W-1:0]);
                  if (master)
                  begin
                     fs_out_ff <= fs_on;
                     // the request edge itself is the first half period of lead
                     state_ff <= (lead_len > 4'h1) ? ST_LEAD : ST_SHIFT;
                  end
                  else
                  begin
                     state_ff <= ST_WAIT;
                  end
               end
            end
            ST_WAIT:
            begin
               if (fs_s == fs_on)
               begin
                  state_ff <= ST_SHIFT;
               end
            end
            ST_LEAD:
            begin
               if (lead_ff <= 4'h1)
               begin
                  state_ff <= ST_SHIFT;
               end
               else
               begin
                  lead_ff <= lead_ff - 4'h1;
               end
            end
            ST_SHIFT:
            begin
               if (tick)
               begin
                  if (master)
                  begin
                     sclk_out_ff <= ~sclk_out_ff;
                  end
                  half_ff <= ~half_ff;
                  if (!half_ff && slot_data)
                  begin
                     rx_sh_ff <= {rx_sh_ff[2*DATA_W-2:0], rxd_s};
                  end
                  if (half_ff)
                  begin
                     slot_ff <= nxt_slot;
                     ch_ff <= nxt_ch;
                     txd_ff <= slot_bit(nxt_slot, word_now);
                     if (frame_end)
                     begin
                        state_ff <= ST_END;
                     end
                     else if (slot_ff == slot_last && master)
                     begin
                        fs_out_ff <= ~fs_on;
                     end
                  end
               end
            end
            ST_END:
            begin
               fs_out_ff <= ~fs_on;
               sclk_out_ff <= sclk_idle;
               txd_ff <= 1'b0;
               done_tgl_ff <= ~done_tgl_ff;
               state_ff <= ST_IDLE;
            end
            default:
            begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   assign SCLK_OUT = sclk_out_ff;
   assign SCLK_OE_OUT = sclk_oe_ff;
   assign FS_OUT = fs_out_ff;
   assign FS_OE_OUT = fs_oe_ff;
   assign TXD_OUT = txd_ff;
endmodule
`default_nettype wire

// ===== serial_port_format_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fmt_ctl_chk #(
   parameter int DATA_W = 16
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic LINK_CLK_IN,
   input wire logic [2:0] FRAME_FORMAT_SELECT_IN,
   input wire logic FRAME_SYNC_POLARITY_IN,
   input wire logic [1:0] OPERATION_MODE_IN,
   input wire logic SERIAL_CLOCK_POLARITY_IN,
   input wire logic SERIAL_CLOCK_PHASE_IN,
   input wire logic START_IN,
   input wire logic BUSY_OUT,
   input wire logic DONE_OUT,
   input wire logic [2*DATA_W-1:0] RX_DATA_OUT,
   input wire logic SCLK_OUT,
   input wire logic SCLK_OE_OUT,
   input wire logic FS_OUT,
   input wire logic FS_OE_OUT
);
   logic [5:0] calm_ff;
   logic [7:0] cfg_ff;
   wire [2:0] fmt = FRAME_FORMAT_SELECT_IN;
   wire [7:0] cfg = {fmt, FRAME_SYNC_POLARITY_IN, OPERATION_MODE_IN,
      SERIAL_CLOCK_POLARITY_IN, SERIAL_CLOCK_PHASE_IN};
   wire quiet = calm_ff == 6'h3F;
   wire [5:0] nxt_calm = (BUSY_OUT || !CE_IN || cfg != cfg_ff) ? 6'h00 :
      calm_ff + {5'h00, !quiet};
   wire spi_m = fmt == fmt_ctl_pkg::FMT_SPI && OPERATION_MODE_IN[1];
   wire fs_lvl = (fmt == fmt_ctl_pkg::FMT_I2S || fmt == fmt_ctl_pkg::FMT_CMD) &&
      FRAME_SYNC_POLARITY_IN;
   // settings held and port idle long enough to cross
   always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
      if (RST_IN)
      begin
         calm_ff <= 6'h00;
         cfg_ff <= 8'h00;
      end
      else
      begin
         calm_ff <= nxt_calm;
         cfg_ff <= cfg;
      end
   fs_idle_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      quiet |-> FS_OUT == fs_lvl) else $error("frame idle level wrong");
   sclk_idle_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      quiet |-> SCLK_OUT == (fmt == fmt_ctl_pkg::FMT_SPI && SERIAL_CLOCK_POLARITY_IN))
      else $error("clock idle level wrong");
   mode_oe_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      quiet |-> SCLK_OE_OUT == OPERATION_MODE_IN[1] && FS_OE_OUT == OPERATION_MODE_IN[1])
      else $error("master enables wrong");
   start_take_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      CE_IN && START_IN && !BUSY_OUT && fmt <= 3'h3 |=> BUSY_OUT)
      else $error("start not taken");
   bad_fmt_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      !BUSY_OUT && fmt > 3'h3 |=> !BUSY_OUT) else $error("reserved format started");
   done_pulse_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      DONE_OUT |-> !BUSY_OUT && $past(BUSY_OUT) ##1 !DONE_OUT) else $error("done or busy wrong");
   rx_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      $changed(RX_DATA_OUT) |-> DONE_OUT) else $error("receive data moved");
   lead_full_a: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      spi_m && !SERIAL_CLOCK_PHASE_IN && $rose(FS_OUT) |=> $stable(SCLK_OUT) ##1
      $changed(SCLK_OUT)) else $error("full period lead wrong");
   lead_half_a: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      spi_m && SERIAL_CLOCK_PHASE_IN && $rose(FS_OUT) |=> $changed(SCLK_OUT))
      else $error("half period lead wrong");
   cover property (@(posedge SYS_CLK_IN) DONE_OUT && OPERATION_MODE_IN == 2'h3);
   cover property (@(posedge SYS_CLK_IN) DONE_OUT && !OPERATION_MODE_IN[1]);
   cover property (@(posedge SYS_CLK_IN) START_IN && !BUSY_OUT && fmt > 3'h3);
endmodule
bind serial_port_format_control fmt_ctl_chk #(.DATA_W(DATA_W)) i_fmt_ctl_chk (.SYS_CLK_IN,
   .RST_IN, .CE_IN, .LINK_CLK_IN, .FRAME_FORMAT_SELECT_IN, .FRAME_SYNC_POLARITY_IN,
   .OPERATION_MODE_IN, .SERIAL_CLOCK_POLARITY_IN, .SERIAL_CLOCK_PHASE_IN, .START_IN,
   .BUSY_OUT, .DONE_OUT, .RX_DATA_OUT, .SCLK_OUT, .SCLK_OE_OUT, .FS_OUT, .FS_OE_OUT);
`default_nettype wire

// ===== serial_port_format_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_format_control_tb_top;
   logic clk = 0, lclk = 0, rst = 1, go = 0, clr = 0, lvl = 0, start = 0;
   logic fpol = 0, just = 0, cpol = 0, cpha = 0;
   logic [2:0] fmt = 0;
   logic [1:0] mode = 0;
   logic [7:0] pad = 0;
   logic [15:0] tx = 0;
   logic [31:0] mq;
   logic [31:0] q[$];
   wire busy, done, sclk, txd, s_clk, s_fs, rxd;
   wire [15:0] rx;
   wire [31:0] cap;
   wire [7:0] cnt;
   int num_errors = 0, compares = 0;
   serial_port_format_control #(.DATA_W(8)) i_serial_port_format_control (
      .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .LINK_CLK_IN(lclk),
      .FRAME_FORMAT_SELECT_IN(fmt), .FRAME_SYNC_POLARITY_IN(fpol), .PADDING_JUSTIFY_IN(just),
      .OPERATION_MODE_IN(mode), .SERIAL_CLOCK_POLARITY_IN(cpol), .SERIAL_CLOCK_PHASE_IN(cpha),
      .PADDING_LENGTH_IN(pad), .START_IN(start), .TX_DATA_IN(tx), .BUSY_OUT(busy),
      .DONE_OUT(done), .RX_DATA_OUT(rx), .SCLK_IN(s_clk), .FS_IN(s_fs), .RXD_IN(rxd),
      .SCLK_OUT(sclk), .SCLK_OE_OUT(), .FS_OUT(), .FS_OE_OUT(), .TXD_OUT(txd));
   serial_peer i_serial_peer (.clk_in(lclk), .rst_in(rst), .clr_in(clr), .go_in(go),
      .lvl_in(lvl), .sclk_in(sclk), .txd_in(txd), .sclk_out(s_clk), .fs_out(s_fs),
      .rxd_out(rxd), .cap_out(cap), .cnt_out(cnt));
   always #2 clk = !clk;
   initial
   begin
      #1.3;
      forever #16 lclk = !lclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic run(input logic [4:0] c);
      logic [31:0] e;
      logic i2s, st;
      int s, k, n, pp;
      @(posedge clk);
      #1;
      fmt = {1'b0, c[4:3]};
      mode = c[2:1];
      just = c[0];
      cpol = c[0];
      cpha = c[1];
      fpol = mode[1] & 1'($urandom);
      pad = 8'($urandom % 4);
      lvl = 1'($urandom);
      tx = 16'($urandom);
      clr = 1;
      i2s = fmt == 3'h3;
      st = i2s && mode[0];
      pp = i2s ? int'(pad) : 0;
      s = (pp + 8) << st;
      e = 32'h0;
      for (k = int'(st); k >= 0; k--)
         e = just ? (e << (pp + 8)) | 32'(tx[k*8 +: 8]) : ((e << 8) | 32'(tx[k*8 +: 8])) << pp;
      repeat (80) @(posedge clk); // settings move only while idle
      #1;
      clr = 0;
      start = 1;
      go = !mode[1];
      q.push_back({st ? 16'hFFFF : 16'h00FF, {16{lvl}}});
      repeat (5) @(posedge clk);
      #1;
      start = 0;
      n = 0;
      while (busy !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      #1;
      go = 0;
      check(32'(busy), 32'h0);
      if (mode[1])
      begin
         check(cap & ((32'h1 << s) - 32'h1), e);
         check(32'(cnt), 32'(s));
      end
   endtask
   always @(posedge clk)
      if (done === 1'b1)
      begin
         check(32'(q.size() > 0), 32'h1);
         mq = q.size() > 0 ? q.pop_front() : 32'h0;
         check(32'(rx & mq[31:16]), 32'(mq[15:0] & mq[31:16]));
      end
   initial
   begin
      #300000;
      num_errors++;
      report_and_stop;
   end
   initial
   begin
      void'($urandom(30));
      repeat (4) @(posedge lclk);
      #1;
      rst = 0;
      for (int i = 0; i < 32; i++)
         run(5'(i));
      for (int f = 4; f < 8; f++)
      begin
         @(posedge clk);
         #1;
         fmt = 3'(f);
         start = 1;
         repeat (80) @(posedge clk);
         check(32'(busy), 32'h0);
      end
      #1;
      start = 0;
      repeat (20) @(posedge clk);
      check(32'(q.size()), 32'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
